// >>> core/txr_pkg.sv
// Purpose: constants for the transmitter pin, threshold and status register slice
// Assumes: byte-wide register port fed by an spi framing block outside
package txr_pkg;
  localparam logic [5:0] ADDR_PIN1_CFG = 6'h01;
  localparam logic [5:0] ADDR_PIN0_CFG = 6'h02;
  localparam logic [5:0] ADDR_THR = 6'h03;
  localparam logic [5:0] ADDR_MARK_HI = 6'h04;
  localparam logic [5:0] ADDR_MARK_LO = 6'h05;
  localparam logic [5:0] ADDR_PART_ID = 6'h30;
  localparam logic [5:0] ADDR_REVISION = 6'h31;
  localparam logic [5:0] ADDR_FSM_STATE = 6'h35;
  localparam logic [5:0] ADDR_PIN_STATE = 6'h38;
  localparam logic [5:0] ADDR_PLL_CAL = 6'h39;
  localparam logic [5:0] ADDR_FILL = 6'h3A;

  localparam logic [7:0] RST_PIN1_CFG = 8'h2E;
  localparam logic [7:0] RST_PIN0_CFG = 8'h3F;
  localparam logic [7:0] RST_THR = 8'h07;
  localparam logic [7:0] RST_MARK_HI = 8'hD3;
  localparam logic [7:0] RST_MARK_LO = 8'h91;

  // arbitrary identity values
  localparam logic [7:0] PART_ID_VAL = 8'h00;
  localparam logic [7:0] REVISION_VAL = 8'h01;

  localparam int BIT_DRIVE = 7;
  localparam int BIT_INV = 6;
  localparam int BIT_TEMP = 7;
  localparam logic [3:0] THR_FIELD_MASK = 4'hF;
  localparam logic [6:0] THR_BASE = 7'h3D;
  localparam logic [5:0] SEL_THRESHOLD = 6'h02;
  localparam logic [5:0] SEL_TRISTATE = 6'h2E;
  localparam logic [5:0] SEL_XTAL_192 = 6'h3F;
  // 96 sampled crystal rises per half period of the divided clock
  localparam logic [7:0] XDIV_LAST = 8'h5F;
  localparam logic [5:0] SEL_LOW = 6'h2F;
  localparam logic [5:0] SEL_HIGH = 6'h2F;
endpackage : txr_pkg

// >>> core/txr_regs.sv
// Purpose: pin config, tx threshold, frame marker and status register slice
// Assumes: one register access per cycle, synchronous inputs from outside logic
// Notes: pin signals leave as level plus output enable, the pad sits outside
// Notes on behaviour
// - read-only fill count and underflow register
// - read-only control state machine state register
// - read-only pin levels and frame status register
// - read-only pll calibration value register
// - read-only part and revision identity registers
// - drive strength bit selects strength both pins
// - invert bit makes pin output active low
// - pin1 select resets to tri-state code
// - pin0 select resets to crystal divided clock
// - threshold reached when count at least limit
// - code maps to 61 minus four times code
// - frame marker high byte, resets to d3
// - frame marker low byte, resets to 91
module txr_regs
  import txr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] fsm_state_i,
  input wire logic [7:0] frame_state_i,
  input wire logic [7:0] pll_cal_i,
  input wire logic tx_underflow_i,
  input wire logic [6:0] tx_fill_i,
  input wire logic crystal_clock_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic [1:0] general_purpose_outputs_o,
  output logic [1:0] pin_oe_o,
  output logic pin_drive_strength_o,
  output logic temp_sensor_en_o,
  output logic tx_thr_reached_o,
  output logic [15:0] frame_marker_o
);
  logic [7:0] pin1_output_config_ff;
  logic [7:0] pin0_output_config_ff;
  logic [7:0] tx_buffer_threshold_ff;
  logic [7:0] frame_marker_high_ff;
  logic [7:0] frame_marker_low_ff;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  logic [1:0] gpo_ff;
  logic [1:0] oe_ff;
  logic thr_ff;
  logic [7:0] xdiv_ff;
  logic xclk_ff;
  logic xprev_ff;

  wire logic wr_pin1 = reg_wr_i && (reg_addr_i == ADDR_PIN1_CFG);
  wire logic wr_pin0 = reg_wr_i && (reg_addr_i == ADDR_PIN0_CFG);
  wire logic wr_thr = reg_wr_i && (reg_addr_i == ADDR_THR);
  wire logic wr_mhi = reg_wr_i && (reg_addr_i == ADDR_MARK_HI);
  wire logic wr_mlo = reg_wr_i && (reg_addr_i == ADDR_MARK_LO);

  // threshold limit: 61 - 4*code
  wire logic [3:0] tx_threshold_code = tx_buffer_threshold_ff[3:0] & THR_FIELD_MASK;
  wire logic [6:0] thr_limit = THR_BASE - {1'b0, tx_threshold_code, 2'b00};
  wire logic nxt_thr = (tx_fill_i >= thr_limit);

  // crystal clock divided by 192: toggle every 96 rising edges
  wire logic x_rise = crystal_clock_i && !xprev_ff;
  wire logic x_wrap = x_rise && (xdiv_ff == XDIV_LAST);
  wire logic [7:0] nxt_xdiv = x_wrap ? 8'h00 : (x_rise ? xdiv_ff + 8'h01 : xdiv_ff);

  wire logic [5:0] sel1 = pin1_output_config_ff[5:0];
  wire logic [5:0] sel0 = pin0_output_config_ff[5:0];
  logic [1:0] nxt_gpo;
  logic [1:0] nxt_oe;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      wire logic [5:0] s = (g == 0) ? sel0 : sel1;
      wire logic i = (g == 0) ? pin0_output_config_ff[BIT_INV] : pin1_output_config_ff[BIT_INV];
      wire logic raw = (s == SEL_THRESHOLD) ? nxt_thr :
                       (s == SEL_XTAL_192) ? xclk_ff : 1'b0;
      assign nxt_gpo[g] = raw ^ i;
      assign nxt_oe[g] = (s != SEL_TRISTATE);
    end
  endgenerate

  // unmapped addresses read as zero
  wire logic [7:0] rd_mux =
    (reg_addr_i == ADDR_PIN1_CFG) ? pin1_output_config_ff :
    (reg_addr_i == ADDR_PIN0_CFG) ? pin0_output_config_ff :
    (reg_addr_i == ADDR_THR) ? tx_buffer_threshold_ff :
    (reg_addr_i == ADDR_MARK_HI) ? frame_marker_high_ff :
    (reg_addr_i == ADDR_MARK_LO) ? frame_marker_low_ff :
    (reg_addr_i == ADDR_PART_ID) ? PART_ID_VAL :
    (reg_addr_i == ADDR_REVISION) ? REVISION_VAL :
    (reg_addr_i == ADDR_FSM_STATE) ? fsm_state_i :
    (reg_addr_i == ADDR_PIN_STATE) ? {frame_state_i[7:2], gpo_ff} :
    (reg_addr_i == ADDR_PLL_CAL) ? pll_cal_i :
    (reg_addr_i == ADDR_FILL) ? {tx_underflow_i, tx_fill_i} :
    8'h00;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin1_output_config_ff <= RST_PIN1_CFG;
      pin0_output_config_ff <= RST_PIN0_CFG;
      tx_buffer_threshold_ff <= RST_THR;
      frame_marker_high_ff <= RST_MARK_HI;
      frame_marker_low_ff <= RST_MARK_LO;
    end else begin
      if (wr_pin1) pin1_output_config_ff <= reg_wdata_i;
      if (wr_pin0) pin0_output_config_ff <= reg_wdata_i;
      if (wr_thr) tx_buffer_threshold_ff <= reg_wdata_i;
      if (wr_mhi) frame_marker_high_ff <= reg_wdata_i;
      if (wr_mlo) frame_marker_low_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
      thr_ff <= 1'b0;
      xdiv_ff <= 8'h00;
      xclk_ff <= 1'b0;
      xprev_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd_i;
      reg_rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
      thr_ff <= nxt_thr;
      xprev_ff <= crystal_clock_i;
      xdiv_ff <= nxt_xdiv;
      if (x_wrap) xclk_ff <= !xclk_ff;
    end
  end

  // pin outputs reset to their reset-select behaviour, pin1 off, pin0 driving
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gpo_ff <= 2'b00;
      oe_ff <= 2'b01;
    end else begin
      gpo_ff <= nxt_gpo;
      oe_ff <= nxt_oe;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign reg_rvalid_o = reg_rvalid_ff;
  assign general_purpose_outputs_o = gpo_ff;
  assign pin_oe_o = oe_ff;
  assign pin_drive_strength_o = pin1_output_config_ff[BIT_DRIVE];
  // host keeps other bits zero when the sensor is on
  assign temp_sensor_en_o = pin0_output_config_ff[BIT_TEMP];
  assign tx_thr_reached_o = thr_ff;
  assign frame_marker_o = {frame_marker_high_ff, frame_marker_low_ff};

  thr_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1 |=> tx_thr_reached_o == $past(tx_fill_i >= thr_limit)) else $error("threshold flag wrong");
  thr_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    thr_limit == 7'd61 - 7'd4 * {3'b000, tx_threshold_code}) else $error("threshold map wrong");
  marker_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_mhi |=> $stable(frame_marker_o[15:8])) else $error("marker high changed");
  marker_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mlo |=> frame_marker_o[7:0] == $past(reg_wdata_i)) else $error("marker low not written");
  status_ro_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == ADDR_FILL) |=> $stable(pin0_output_config_ff)
    && $stable(pin1_output_config_ff)) else $error("status write had effect");
  fill_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_FILL) |=>
    reg_rvalid_o && reg_rdata_o == {$past(tx_underflow_i), $past(tx_fill_i)})
    else $error("fill read wrong");
  fsm_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_FSM_STATE) |=> reg_rdata_o == $past(fsm_state_i))
    else $error("state read wrong");
  tristate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel1 == SEL_TRISTATE) |=> !pin_oe_o[1]) else $error("pin1 not tri-state");
  invert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel0 == SEL_THRESHOLD) |=> general_purpose_outputs_o[0] ==
    ($past(nxt_thr) ^ $past(pin0_output_config_ff[BIT_INV]))) else $error("invert wrong");

  // reset values land on the edge after a reset edge, so no disable here
  pin1_sel_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    pin1_output_config_ff[5:0] == SEL_TRISTATE)
    else $error("pin1 select reset wrong");

  pin0_sel_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    pin0_output_config_ff[5:0] == SEL_XTAL_192)
    else $error("pin0 select reset wrong");

  inv_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    !pin0_output_config_ff[BIT_INV] && !pin1_output_config_ff[BIT_INV])
    else $error("invert reset wrong");

  drive_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    !pin_drive_strength_o)
    else $error("drive reset wrong");

  thr_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    tx_buffer_threshold_ff == RST_THR)
    else $error("threshold reset wrong");

  mark_hi_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    frame_marker_o[15:8] == RST_MARK_HI)
    else $error("marker high reset wrong");

  mark_lo_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    frame_marker_o[7:0] == RST_MARK_LO)
    else $error("marker low reset wrong");

  temp_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    !temp_sensor_en_o)
    else $error("sensor enable reset wrong");

  rvalid_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    !reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("read port reset wrong");

  oe_rst_a: assert property (@(posedge clk_i)
    !rst_n_i |=>
    !pin_oe_o[1] && pin_oe_o[0])
    else $error("enable reset wrong");

  // writes
  drive_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pin1 |=>
    pin_drive_strength_o == $past(reg_wdata_i[BIT_DRIVE]))
    else $error("drive not written");

  inv1_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pin1 |=>
    pin1_output_config_ff[BIT_INV] == $past(reg_wdata_i[BIT_INV]))
    else $error("pin1 invert not written");

  inv0_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pin0 |=>
    pin0_output_config_ff[BIT_INV] == $past(reg_wdata_i[BIT_INV]))
    else $error("pin0 invert not written");

  temp_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pin0 |=>
    temp_sensor_en_o == $past(reg_wdata_i[BIT_TEMP]))
    else $error("sensor enable not written");

  thr_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_thr |=>
    tx_buffer_threshold_ff == $past(reg_wdata_i))
    else $error("threshold not stored as written");

  mark_hi_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mhi |=>
    frame_marker_o[15:8] == $past(reg_wdata_i))
    else $error("marker high not written");

  mark_lo_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_mlo |=>
    $stable(frame_marker_o[7:0]))
    else $error("marker low changed");

  status_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == ADDR_PART_ID) |=>
    $stable(tx_buffer_threshold_ff) && $stable(frame_marker_o))
    else $error("identity write had effect");

  // reads
  part_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_PART_ID) |=>
    reg_rvalid_o && reg_rdata_o == PART_ID_VAL)
    else $error("part read wrong");

  rev_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_REVISION) |=>
    reg_rvalid_o && reg_rdata_o == REVISION_VAL)
    else $error("revision read wrong");

  pin_state_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_PIN_STATE) |=>
    reg_rdata_o == {$past(frame_state_i[7:2]), $past(general_purpose_outputs_o)})
    else $error("pin state read wrong");

  pll_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_PLL_CAL) |=>
    reg_rvalid_o && reg_rdata_o == $past(pll_cal_i))
    else $error("calibration read wrong");

  rvalid_rise_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i |=>
    reg_rvalid_o)
    else $error("read not answered");

  idle_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=>
    !reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("read data outside a read");

  // threshold flag, checked against its bounds rather than the adder
  thr_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_fill_i >= THR_BASE) |=>
    tx_thr_reached_o)
    else $error("full buffer not flagged");

  thr_empty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_fill_i == 7'h00) |=>
    !tx_thr_reached_o)
    else $error("empty buffer flagged");

  thr_code_max_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_threshold_code == 4'hF) && (tx_fill_i != 7'h00) |=>
    tx_thr_reached_o)
    else $error("top code limit wrong");

  thr_code_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_threshold_code == 4'h0) && (tx_fill_i < THR_BASE) |=>
    !tx_thr_reached_o)
    else $error("zero code limit wrong");

  thr_pin1_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel1 == SEL_THRESHOLD) |=>
    general_purpose_outputs_o[1] == ($past(nxt_thr) ^ $past(pin1_output_config_ff[BIT_INV])))
    else $error("pin1 threshold wrong");

  // crystal divider
  xdiv_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |->
    xdiv_ff <= XDIV_LAST)
    else $error("divider out of range");

  xclk_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !x_wrap |=>
    $stable(xclk_ff))
    else $error("divided clock moved early");

  xtal_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel0 == SEL_XTAL_192) |=>
    general_purpose_outputs_o[0] == ($past(xclk_ff) ^ $past(pin0_output_config_ff[BIT_INV])))
    else $error("pin0 clock wrong");

  oe_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel0 != SEL_TRISTATE) |=>
    pin_oe_o[0])
    else $error("pin0 not driven");
endmodule : txr_regs

// >>> bench/txr_host.sv
// Purpose: host model issuing single register writes and reads
// Assumes: strobes change on falling edges, one access at a time
// Notes: released address and data are inverted, never left stale
module txr_host
  import txr_pkg::*;
(
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [5:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 6'h3F;
    wdata_o = 8'h00;
  end
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : access
  // clock output off early, it disturbs the radio
  task automatic init();
    access(1'b1, ADDR_PIN0_CFG, {2'b00, SEL_TRISTATE});
  endtask : init
endmodule : txr_host

// >>> bench/txr_regs_tb.sv
// Purpose: self-checking bench for the pin, threshold and status slice
// Assumes: inputs change on falling edges, host model makes accesses
// Notes: status inputs held steady, fill until the table is done, so read-back values are known
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module tx_radio_pin_fifo_config_regs_tb_top
  import txr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [5:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e;} txr_row_t;
  logic clk_i, rst_n_i, wr, rd, unf, xtal, rv, ds, temp, thr;
  logic [5:0] addr;
  logic [6:0] fill;
  logic [7:0] wd, rdat;
  logic [1:0] gpo, oe;
  logic [15:0] mark;
  int fails = 0, tests_run = 0, cyc = 0;
  txr_row_t rows [12] = '{
    '{ADDR_PIN1_CFG, RST_PIN1_CFG, 8'hC2, 8'hC2},
    '{ADDR_PIN0_CFG, RST_PIN0_CFG, 8'h80, 8'h80},
    '{ADDR_THR, RST_THR, 8'h0F, 8'h0F},
    '{ADDR_MARK_HI, RST_MARK_HI, 8'h5A, 8'h5A},
    '{ADDR_MARK_LO, RST_MARK_LO, 8'hA5, 8'hA5},
    '{ADDR_PART_ID, PART_ID_VAL, 8'hFF, PART_ID_VAL},
    '{ADDR_REVISION, REVISION_VAL, 8'hFF, REVISION_VAL},
    '{ADDR_FSM_STATE, 8'h0D, 8'hFF, 8'h0D},
    '{ADDR_PLL_CAL, 8'h5C, 8'h00, 8'h5C},
    '{ADDR_FILL, 8'hA1, 8'h00, 8'hA1},
    '{ADDR_PIN_STATE, 8'hFC, 8'hFF, 8'hFC},
    '{6'h20, 8'h00, 8'h77, 8'h00}};
  txr_host txr_host_inst (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
  txr_regs txr_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .fsm_state_i(8'h0D), .frame_state_i(8'hFC),
    .pll_cal_i(8'h5C), .tx_underflow_i(unf), .tx_fill_i(fill), .crystal_clock_i(xtal),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv), .general_purpose_outputs_o(gpo), .pin_oe_o(oe),
    .pin_drive_strength_o(ds), .temp_sensor_en_o(temp), .tx_thr_reached_o(thr),
    .frame_marker_o(mark));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] x);
    txr_host_inst.access(1'b0, a, 8'h00);
    `CHK("rvalid", 1'b1, rv)
    `CHK("rdata", x, rdat)
  endtask : rd_chk
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // slow crystal stand-in, well under half the clock rate
  always #700 xtal = ~xtal;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    unf = 1'b1;
    fill = 7'h21;
    xtal = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (rows[i]) begin
      rd_chk(rows[i].a, rows[i].r);
      txr_host_inst.access(1'b1, rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    `CHK("mark", 16'h5AA5, mark)
    `CHK("drive", 1'b1, ds)
    `CHK("temp", 1'b1, temp)
    $display("test table done");
    for (int c = 0; c < 16; c++) begin
      txr_host_inst.access(1'b1, ADDR_THR, 8'(c));
      fill = 7'(60 - 4 * c);
      repeat (3) @(negedge clk_i);
      `CHK("below", 1'b0, thr)
      fill = 7'(61 - 4 * c);
      repeat (3) @(negedge clk_i);
      `CHK("at", 1'b1, thr)
      `CHK("pin1", 2'b10, {oe[1], gpo[1]})
    end
    $display("test threshold done");
    rst_n_i = 1'b0;
    @(negedge clk_i);
    rst_n_i = 1'b1;
    `CHK("mark", {RST_MARK_HI, RST_MARK_LO}, mark)
    `CHK("oe", 2'b01, oe)
    `CHK("drive", 1'b0, ds)
    repeat (2500) @(negedge clk_i);
    `CHK("xtal_lo", 1'b0, gpo[0])
    repeat (300) @(negedge clk_i);
    `CHK("xtal_hi", 1'b1, gpo[0])
    txr_host_inst.init();
    repeat (3) @(negedge clk_i);
    `CHK("oe", 2'b00, oe)
    $display("test reset done");
    complete_run();
  end
endmodule : tx_radio_pin_fifo_config_regs_tb_top
